/* core/swp_pkg.sv */
package swp_pkg;

    // configuration word layout
    localparam int CFG_WIDTH          = 24;
    localparam int BIT_END_SELECT     = 15;
    localparam int BIT_CFG_PROTECT_N  = 14;
    localparam int BIT_SEG_DISABLE    = 13;
    localparam int WAKE_LSB           = 10;
    localparam int OSC_LSB            = 8;
    localparam int PAGE_LSB           = 0;
    localparam int PAGE_WIDTH         = 6;
    localparam logic [23:0] CFG_UNUSED_MASK  = 24'hff10c0;
    localparam logic [23:0] CFG_RESET_VALUE  = 24'hffffff;

    // program memory geometry
    localparam int ADDR_WIDTH         = 24;
    localparam int PAGE_SHIFT         = 9;
    localparam int PAGE_INSTRUCTIONS  = 512;
    localparam logic [5:0] LAST_PAGE  = 6'h3f;

    // wake-up and oscillator codes
    localparam logic [1:0] WAKE_DEFAULT = 2'h3;
    localparam logic [1:0] WAKE_FAST    = 2'h1;
    localparam logic [1:0] OSC_HIGH     = 2'h3;
    localparam logic [1:0] OSC_RESERVED = 2'h2;
    localparam logic [1:0] OSC_LOW      = 2'h1;
    localparam logic [1:0] OSC_DIGITAL  = 2'h0;

    // register byte offsets
    localparam logic [7:0] OFS_CONFIG = 8'h00;
    localparam logic [7:0] OFS_BOUNDS = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_CTRL   = 8'h0c;

    // bounds register fields
    localparam int BND_LO_LSB     = 0;
    localparam int BND_HI_LSB     = 8;
    localparam int BND_SEG_BIT    = 16;
    localparam int BND_CFGP_BIT   = 17;
    // status register fields
    localparam int STS_BLOCK_BIT  = 0;
    localparam int STS_ADDR_LSB   = 8;
    // control register fields
    localparam int CTRL_RELOAD_BIT = 0;

    typedef enum logic [1:0]
    {
        OSC_MODE_DIGITAL  = 2'h0,
        OSC_MODE_LOW      = 2'h1,
        OSC_MODE_RESERVED = 2'h2,
        OSC_MODE_HIGH     = 2'h3
    } swp_osc_mode_type;

    typedef struct packed
    {
        logic                   segment_end_select;
        logic                   config_page_protect_n;
        logic                   segment_protect_disable;
        logic [1:0]             regulator_wake_time_sel;
        logic [1:0]             secondary_osc_mode_sel;
        logic [PAGE_WIDTH-1:0]  boundary_page_index;
    } swp_fields_type;

    typedef struct packed
    {
        logic                   seg_active;
        logic                   cfg_protected;
        logic [PAGE_WIDTH-1:0]  lo_page;
        logic [PAGE_WIDTH-1:0]  hi_page;
    } swp_region_type;

    typedef struct packed
    {
        logic                   req;
        logic                   erase;
        logic                   cfg_target;
        logic [ADDR_WIDTH-1:0]  addr;
    } swp_prog_req_type;

endpackage : swp_pkg

/* core/swp_field_decode.sv */
`timescale 1ns/10ps
module swp_field_decode
    import swp_pkg::*;
(
    input  wire logic [CFG_WIDTH-1:0] i_word,
    output swp_fields_type            o_fields,
    output swp_region_type            o_region
);

    always_comb
    begin
        o_fields.segment_end_select      = i_word[BIT_END_SELECT];
        o_fields.config_page_protect_n   = i_word[BIT_CFG_PROTECT_N];
        o_fields.segment_protect_disable = i_word[BIT_SEG_DISABLE];
        o_fields.regulator_wake_time_sel = i_word[WAKE_LSB +: 2];
        o_fields.secondary_osc_mode_sel  = i_word[OSC_LSB +: 2];
        o_fields.boundary_page_index     = i_word[PAGE_LSB +: PAGE_WIDTH];
        // disable kills all segmented protection
        o_region.seg_active    = ~o_fields.segment_protect_disable;
        o_region.cfg_protected = ~o_fields.segment_protect_disable &
                                 ~o_fields.config_page_protect_n;
        if (o_fields.segment_end_select)
        begin
            o_region.lo_page = '0;
            o_region.hi_page = o_fields.boundary_page_index;
        end
        else
        begin
            o_region.lo_page = o_fields.boundary_page_index;
            o_region.hi_page = LAST_PAGE;
        end
    end

endmodule : swp_field_decode

/* core/swp_range_check.sv */
`timescale 1ns/10ps
module swp_range_check
    import swp_pkg::*;
(
    input  wire logic [ADDR_WIDTH-1:0] i_addr,
    input  wire logic                  i_cfg_target,
    input  swp_region_type             i_region,
    output logic                       o_hit
);

    logic [PAGE_WIDTH-1:0] page;
    logic                  high_bits;
    logic                  in_seg;
    logic                  in_cfg;

    always_comb
    begin
        // pages of 512 instructions counted from the bottom
        page      = i_addr[PAGE_SHIFT +: PAGE_WIDTH];
        high_bits = |i_addr[ADDR_WIDTH-1:PAGE_SHIFT+PAGE_WIDTH];
        in_seg    = i_region.seg_active & ~high_bits &
                    (page >= i_region.lo_page) &
                    (page <= i_region.hi_page);
        in_cfg    = i_region.cfg_protected &
                    (i_cfg_target | (~high_bits & page == LAST_PAGE));
        o_hit     = in_seg | in_cfg;
    end

endmodule : swp_range_check

/* core/swp_config_top.sv */
// The implementer's own choices: the register addresses and strobed register access.
`timescale 1ns/10ps
module swp_config_top
    import swp_pkg::*;
(
    input  wire logic                  i_core_clk,
    input  wire logic                  i_rst,
    input  wire logic [CFG_WIDTH-1:0]  i_nv_config_word,
    input  wire logic [7:0]            i_addr,
    input  wire logic [31:0]           i_wr_data,
    input  wire logic                  i_wr_stb,
    input  wire logic                  i_rd_stb,
    output logic      [31:0]           o_rd_data,
    input  wire logic                  i_prog_req,
    input  wire logic                  i_prog_erase,
    input  wire logic                  i_prog_cfg_target,
    input  wire logic [ADDR_WIDTH-1:0] i_prog_addr,
    output logic                       o_prog_ack,
    output logic                       o_prog_allow,
    output logic                       o_prog_blocked,
    output logic [1:0]                 o_regulator_wake_time_sel,
    output logic                       o_wake_fast,
    output logic                       o_wake_reserved,
    output swp_osc_mode_type           o_secondary_osc_mode,
    output logic                       o_osc_high_drive,
    output logic                       o_osc_digital_io,
    output logic                       o_osc_reserved,
    output swp_region_type             o_region
);

    logic [CFG_WIDTH-1:0]  cfg_word;
    logic                  loaded;
    logic                  capture;
    swp_fields_type        fields;
    swp_region_type        region;
    swp_prog_req_type      req;
    logic                  hit;
    logic                  block_flag;
    logic [ADDR_WIDTH-1:0] block_addr;
    logic                  block_event;
    logic                  block_clear;
    logic                  reload_wr;
    logic [31:0]           cfg_rd_word;
    logic [31:0]           bounds_rd_word;
    logic [31:0]           status_rd_word;
    logic [31:0]           ctrl_rd_word;
    logic [31:0]           next_rd_data;

    // request fields gathered into one carrier
    assign req = '{req:        i_prog_req,
                   erase:      i_prog_erase,
                   cfg_target: i_prog_cfg_target,
                   addr:       i_prog_addr};

    assign reload_wr   = i_wr_stb & (i_addr == OFS_CTRL) &
                         i_wr_data[CTRL_RELOAD_BIT];
    assign block_clear = i_wr_stb & (i_addr == OFS_STATUS) &
                         i_wr_data[STS_BLOCK_BIT];
    assign block_event = req.req & hit;
    // a reload request in the same cycle postpones the capture
    assign capture     = ~loaded & ~reload_wr;

    // capture done flag, cleared again by a reload request
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            loaded <= 1'b0;
        end
        else if (reload_wr)
        begin
            loaded <= 1'b0;
        end
        else if (capture)
        begin
            loaded <= 1'b1;
        end
    end

    // word capture after reset release or reload request
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            cfg_word <= CFG_RESET_VALUE;
        end
        else if (capture)
        begin
            cfg_word <= i_nv_config_word | CFG_UNUSED_MASK;
        end
    end

    swp_field_decode u_decode
    (
        .i_word   (cfg_word),
        .o_fields (fields),
        .o_region (region)
    );

    swp_range_check u_check
    (
        .i_addr       (req.addr),
        .i_cfg_target (req.cfg_target),
        .i_region     (region),
        .o_hit        (hit)
    );

    // request acknowledge, one cycle after the request
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            o_prog_ack <= 1'b0;
        end
        else
        begin
            o_prog_ack <= req.req;
        end
    end

    // permission pulse, only once the word is captured
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            o_prog_allow <= 1'b0;
        end
        else
        begin
            o_prog_allow <= req.req & ~hit & loaded;
        end
    end

    // suppression pulse, also while a capture is pending
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            o_prog_blocked <= 1'b0;
        end
        else
        begin
            o_prog_blocked <= req.req & (hit | ~loaded);
        end
    end

    // sticky blocked flag, set wins over clear
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            block_flag <= 1'b0;
        end
        else if (block_event)
        begin
            block_flag <= 1'b1;
        end
        else if (block_clear)
        begin
            block_flag <= 1'b0;
        end
    end

    // address of the latest request that hit the protected range
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            block_addr <= '0;
        end
        else if (block_event)
        begin
            block_addr <= req.addr;
        end
    end

    // wake-up time select to the regulator
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            o_regulator_wake_time_sel <= WAKE_DEFAULT;
            o_wake_fast               <= 1'b0;
            o_wake_reserved           <= 1'b0;
        end
        else
        begin
            o_regulator_wake_time_sel <= fields.regulator_wake_time_sel;
            o_wake_fast     <= fields.regulator_wake_time_sel
                               == WAKE_FAST;
            o_wake_reserved <= ~fields.regulator_wake_time_sel[0];
        end
    end

    // oscillator pin mode to the pad logic
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            o_secondary_osc_mode <= OSC_MODE_HIGH;
            o_osc_high_drive     <= 1'b1;
            o_osc_digital_io     <= 1'b0;
            o_osc_reserved       <= 1'b0;
        end
        else
        begin
            o_secondary_osc_mode <=
                swp_osc_mode_type'(fields.secondary_osc_mode_sel);
            o_osc_high_drive <= fields.secondary_osc_mode_sel
                                == OSC_HIGH;
            o_osc_digital_io <= fields.secondary_osc_mode_sel
                                == OSC_DIGITAL;
            o_osc_reserved   <= fields.secondary_osc_mode_sel
                                == OSC_RESERVED;
        end
    end

    // protected range to the programming sequencer
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            o_region <= '0;
        end
        else
        begin
            o_region <= region;
        end
    end

    // read views of the four registers
    always_comb
    begin
        cfg_rd_word    = '0;
        bounds_rd_word = '0;
        status_rd_word = '0;
        ctrl_rd_word   = '0;
        cfg_rd_word[CFG_WIDTH-1:0] = cfg_word | CFG_UNUSED_MASK;
        bounds_rd_word[BND_LO_LSB +: PAGE_WIDTH]   = region.lo_page;
        bounds_rd_word[BND_HI_LSB +: PAGE_WIDTH]   = region.hi_page;
        bounds_rd_word[BND_SEG_BIT]                = region.seg_active;
        bounds_rd_word[BND_CFGP_BIT]               = region.cfg_protected;
        status_rd_word[STS_BLOCK_BIT]              = block_flag;
        status_rd_word[STS_ADDR_LSB +: ADDR_WIDTH] = block_addr;
        ctrl_rd_word[CTRL_RELOAD_BIT]              = ~loaded;
    end

    // register read mux, unmapped offsets read zero
    always_comb
    begin
        next_rd_data = '0;
        if (i_rd_stb)
        begin
            case (i_addr)
                OFS_CONFIG:
                begin
                    next_rd_data = cfg_rd_word;
                end
                OFS_BOUNDS:
                begin
                    next_rd_data = bounds_rd_word;
                end
                OFS_STATUS:
                begin
                    next_rd_data = status_rd_word;
                end
                OFS_CTRL:
                begin
                    next_rd_data = ctrl_rd_word;
                end
                default:
                begin
                    next_rd_data = '0;
                end
            endcase
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            o_rd_data <= '0;
        end
        else
        begin
            o_rd_data <= next_rd_data;
        end
    end

endmodule : swp_config_top

/* tb/swp_config_assertions.sv */
`timescale 1ns/10ps
module swp_config_assertions
    import swp_pkg::*;
(
    input wire logic             i_core_clk,
    input wire logic             i_rst,
    input wire logic [23:0]      i_nv_config_word,
    input wire logic [7:0]       i_addr,
    input wire logic             i_rd_stb,
    input wire logic [31:0]      o_rd_data,
    input wire logic             i_prog_req,
    input wire logic             i_prog_cfg_target,
    input wire logic             o_prog_ack,
    input wire logic             o_prog_allow,
    input wire logic             o_prog_blocked,
    input wire logic [1:0]       o_regulator_wake_time_sel,
    input wire logic             o_wake_fast,
    input wire logic             o_wake_reserved,
    input swp_osc_mode_type      o_secondary_osc_mode,
    input wire logic             o_osc_high_drive,
    input swp_region_type        o_region
);
    default clocking @(posedge i_core_clk);
    endclocking
    default disable iff (i_rst);
    // capture after release, then two edges to decode
    sequence s_boot;
        $fell(i_rst) ##1 !i_rst [*2];
    endsequence
    sequence s_bottom;
        s_boot ##0 (!i_nv_config_word[13] && i_nv_config_word[15]);
    endsequence
    sequence s_top;
        s_boot ##0 (!i_nv_config_word[13] && !i_nv_config_word[15]);
    endsequence
    AST_END_BOTTOM: assert property (s_bottom |->
        o_region.lo_page == 6'h00 &&
        o_region.hi_page == i_nv_config_word[5:0]) else $error("bottom");
    AST_END_TOP: assert property (s_top |-> o_region.hi_page == LAST_PAGE
        && o_region.lo_page == i_nv_config_word[5:0]) else $error("top");
    AST_CFG_GUARD: assert property (s_boot ##0 !i_nv_config_word[13] |->
        o_region.seg_active && o_region.cfg_protected == !i_nv_config_word[14])
        else $error("config page guard");
    AST_DISABLE: assert property (s_boot ##0 i_nv_config_word[13] |->
        !o_region.seg_active && !o_region.cfg_protected) else $error("disable");
    AST_ACK: assert property (i_prog_req |=> o_prog_ack
        && (o_prog_allow != o_prog_blocked)) else $error("ack");
    AST_NO_ACK: assert property (!i_prog_req |=> !o_prog_ack
        && !o_prog_allow && !o_prog_blocked) else $error("stray ack");
    AST_CFG_BLOCK: assert property (i_prog_req && i_prog_cfg_target |=>
        !o_region.cfg_protected || o_prog_blocked)
        else $error("config write not blocked");
    AST_RD_ONES: assert property (i_rd_stb && i_addr == OFS_CONFIG |=>
        (o_rd_data[23:0] & CFG_UNUSED_MASK) == CFG_UNUSED_MASK)
        else $error("unused bits");
    AST_WAKE: assert property (o_wake_fast == (o_regulator_wake_time_sel
        == WAKE_FAST) && o_wake_reserved == !o_regulator_wake_time_sel[0])
        else $error("wake decode");
    AST_OSC: assert property (o_osc_high_drive ==
        (o_secondary_osc_mode == OSC_MODE_HIGH)) else $error("osc decode");
endmodule : swp_config_assertions

bind swp_config_top swp_config_assertions i_chk (.*);

/* tb/tb_top.sv */
`timescale 1ns/10ps
module tb_top
    import swp_pkg::*;
;
    logic             i_core_clk = 1'b0;
    logic             i_rst = 1'b1;
    logic [23:0]      i_nv_config_word = 24'h000000;
    logic [7:0]       i_addr = 8'h00;
    logic [31:0]      i_wr_data = 32'h0;
    logic             i_wr_stb = 1'b0;
    logic             i_rd_stb = 1'b0;
    logic             i_prog_req = 1'b0;
    logic             i_prog_erase = 1'b0;
    logic             i_prog_cfg_target = 1'b0;
    logic [23:0]      i_prog_addr = 24'h000000;
    logic [31:0]      o_rd_data;
    logic             o_prog_ack;
    logic             o_prog_allow;
    logic             o_prog_blocked;
    logic [1:0]       o_regulator_wake_time_sel;
    logic             o_wake_fast;
    logic             o_wake_reserved;
    swp_osc_mode_type o_secondary_osc_mode;
    logic             o_osc_high_drive;
    logic             o_osc_digital_io;
    logic             o_osc_reserved;
    swp_region_type   o_region;
    int               num_errors = 0;
    int               checks_done = 0;
    logic [23:0]      last_blk;
    logic             blk_seen;
    logic [23:0]      w;
    logic [23:0]      pa;
    logic [31:0]      d;
    logic [23:0]      words [4] = '{24'h00cf05, 24'h00060a, 24'h00a13f,
                                    24'h004800};

    always #4 i_core_clk = ~i_core_clk;

    swp_config_top i_dut (.*);

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen,
                exp);
        end
    endtask : check

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge i_core_clk);
        i_addr <= a;
        i_rd_stb <= 1'b1;
        @(posedge i_core_clk);
        i_rd_stb <= 1'b0;
        #1;
        v = o_rd_data;
    endtask : rd

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge i_core_clk);
        i_addr <= a;
        i_wr_data <= v;
        i_wr_stb <= 1'b1;
        @(posedge i_core_clk);
        i_wr_stb <= 1'b0;
    endtask : wr

    // expected suppression: segment bounds inclusive, page 63 is last
    function automatic logic exp_blk(logic [23:0] cw, logic [23:0] a,
        logic c);
        logic [5:0] pg;
        logic [5:0] lo;
        logic [5:0] hi;
        pg = a[14:9];
        lo = cw[15] ? 6'h00 : cw[5:0];
        hi = cw[15] ? cw[5:0] : LAST_PAGE;
        return !cw[13] && ((pg >= lo && pg <= hi)
            || (!cw[14] && (c || pg == LAST_PAGE)));
    endfunction : exp_blk

    // probes inside program memory only
    task automatic probe(input logic [23:0] a, input logic c);
        if (a[23:15] == 9'h000)
        begin
            @(posedge i_core_clk);
            i_prog_addr <= a;
            i_prog_cfg_target <= c;
            i_prog_erase <= ~i_prog_erase;
            i_prog_req <= 1'b1;
            @(posedge i_core_clk);
            i_prog_req <= 1'b0;
            #1;
            check(o_prog_ack, 32'h1);
            check(o_prog_blocked, exp_blk(w, a, c));
            check(o_prog_allow, !exp_blk(w, a, c));
            if (exp_blk(w, a, c))
            begin
                blk_seen = 1'b1;
                last_blk = a;
            end
        end
    endtask : probe

    task automatic give_verdict;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : give_verdict

    initial
    begin
        repeat (3000) @(posedge i_core_clk);
        num_errors++;
        give_verdict();
    end

    initial
    begin
        for (int k = 0; k < 4; k++)
        begin
            w = words[k];
            @(posedge i_core_clk);
            i_rst <= 1'b1;
            i_nv_config_word <= w;
            repeat (20) @(posedge i_core_clk);
            i_rst <= 1'b0;
            repeat (3) @(posedge i_core_clk);
            #1;
            check(o_regulator_wake_time_sel, w[11:10]);
            check(o_wake_fast, w[11:10] == WAKE_FAST);
            check(o_wake_reserved, !w[10]);
            check(o_secondary_osc_mode, w[9:8]);
            check(o_osc_high_drive, w[9:8] == OSC_HIGH);
            check(o_osc_digital_io, w[9:8] == OSC_DIGITAL);
            check(o_osc_reserved, w[9:8] == OSC_RESERVED);
            rd(OFS_CONFIG, d);
            check(d, {8'h00, w | CFG_UNUSED_MASK});
            rd(OFS_BOUNDS, d);
            check(d[17:16], {!w[13] && !w[14], !w[13]});
            if (!w[13])
                check({d[13:8], d[5:0]}, w[15] ? {w[5:0], 6'h00}
                    : {LAST_PAGE, w[5:0]});
            pa = {9'h000, w[5:0], 9'h000};
            blk_seen = 1'b0;
            probe(pa, 1'b0);
            probe(pa - 24'h1, 1'b0);
            probe(pa + 24'h1ff, 1'b0);
            probe(pa + 24'h200, 1'b0);
            probe(24'h007e00, 1'b1);
            if (blk_seen)
            begin
                rd(OFS_STATUS, d);
                check(d, {last_blk, 8'h01});
                wr(OFS_STATUS, 32'h1);
                rd(OFS_STATUS, d);
                check(d[0], 32'h0);
            end
        end
        wr(OFS_CONFIG, 32'h0);
        rd(OFS_CONFIG, d);
        check(d, {8'h00, w | CFG_UNUSED_MASK});
        rd(8'h10, d);
        check(d, 32'h0);
        @(posedge i_core_clk);
        i_nv_config_word <= words[0];
        wr(OFS_CTRL, 32'h1);
        repeat (3) @(posedge i_core_clk);
        rd(OFS_CONFIG, d);
        check(d, {8'h00, words[0] | CFG_UNUSED_MASK});
        give_verdict();
    end
endmodule : tb_top
